// ### rtl/write_crc_check.sv
// Purpose: write burst checksum check, error pulse, status and lane inversion
// Assumes: eight-bit device, inputs synchronous to clk_sys
// Notes: error line is open drain; out is held low, oe pulls it
//
// Overview of operation
// RL1: chopped burst tree chosen by burst_half_select
// RL2: 36 tree inputs, missing beats fed ones
// RL3: high half select uses upper nibbles
// RL4: pin bits enter tree only when enabled
// RL5: mismatch starts error reporting next clock
// RL6: checksum errors share the error line
// RL7: short error pulse, parity pulses longer
// RL8: controller tells pulse types apart
// RL9: controller tolerates overlapping chained pulses
// RL10: width counted from drive to release
// RL11: mismatch sets mode word five status
// RL12: status also sets readout error flag
// RL13: both stay set until controller clears
// RL14: controller retries failed writes
// RL15: controller buffers writes for replay
// RL16: controller may attribute errors to transactions
// RL17: same error timing for all widths
// RL18: no lane inversion on four-bit parts
// RL19: inversion keeps fewer than half low; code leaves a beat with four zeros uninverted
// RL20: flag low inverts received lane data
// RL21: mask, inversion, strobe option share pin
// RL22: controller never enables mask with inversion
// RL23: no read inversion on readout reads
// RL24: read inversion selected independently
// RL25: strobe option only with others off
// RL26: fixed latency from compare to pulse; a mismatch while busy waits until the current pulse ends
`timescale 1ns/1ns
`include "write_crc_map.svh"
module write_crc_check #(
	parameter int DEVICE_WIDTH = 8,
	parameter int BUFFER_DEPTH = 2
) (
	input wire logic clk_sys,
	input wire logic reset,
	input wire logic burst_valid,
	output logic write_ready,
	input wire logic [71:0] burst_data,
	input wire logic chopped_four_beat_burst,
	input wire logic burst_half_select,
	input wire logic [7:0] burst_checksum,
	input wire logic mode_set_command,
	input wire logic mode_set_select,
	input wire logic [15:0] mode_set_value,
	output logic storage_valid,
	input wire logic storage_ready,
	output logic [63:0] storage_data,
	output logic [7:0] storage_enable,
	input wire logic read_beat_valid,
	input wire logic [7:0] read_beat,
	input wire logic read_from_readout,
	output logic read_valid,
	output logic [7:0] read_dq,
	output logic read_invert_flag,
	input wire logic error_flag_line_in,
	output logic error_flag_line_out,
	output logic error_flag_line_oe,
	output logic error_status,
	output logic readout_error_flag,
	output logic mask_enabled,
	output logic write_invert_enabled,
	output logic read_invert_enabled,
	output logic termination_strobe_enabled
);
	localparam int LAT_CYC_RAW = (`ERR_LATENCY_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
	localparam int LAT_CYC = (LAT_CYC_RAW < 1) ? 1 : LAT_CYC_RAW;
	localparam logic [7:0] LAT_COUNT = 8'(LAT_CYC - 1);
	localparam logic [7:0] PULSE_COUNT = `ERR_PULSE_CLOCKS - 8'h01;
	localparam logic INVERT_ALLOWED = (DEVICE_WIDTH != 4); // RL18

	generate
		if (DEVICE_WIDTH != 8 || BUFFER_DEPTH < 2) begin : g_bad
			$error("write_crc_check: only an eight-bit tree and depth >= 2 are built");
		end
	endgenerate

	typedef struct packed {
		logic write_ready;
		logic stage_valid;
		logic stage_fresh;
		logic stage_mismatch;
		logic stage_drop;
		logic [63:0] stage_data;
		logic [7:0] stage_enable;
		logic mask_en;
		logic winv_en;
		logic rinv_en;
		logic tso_en;
		logic error_status;
		logic readout_flag;
		write_crc_pkg::alert_state_e alert_state;
		logic [7:0] alert_count;
		logic alert_pending;
		logic alert_drive;
		logic read_valid;
		logic [7:0] read_dq;
		logic read_flag;
	} core_state_s;

	core_state_s s;
	core_state_s next_s;
	logic buf_in_ready;
	logic trigger;

	// serial checksum over the tree bits in index order
	function automatic logic [7:0] crc8(input logic [71:0] tree);
		logic [7:0] c;
		logic fb;
		c = `CRC_INIT;
		fb = 1'b0;
		for (int i = 0; i < `TREE_BITS; i++) begin
			fb = c[7] ^ tree[i];
			c = {c[6:0], 1'b0} ^ (fb ? `CRC_POLY : 8'h00);
		end
		return c;
	endfunction : crc8

	// tree input: lane-major, lane 8 is the shared pin
	function automatic logic [71:0] build_tree(input logic [71:0] d, input logic chop,
		input logic half, input logic pin_on);
		logic [71:0] t;
		t = d;
		if (chop) begin
			for (int lane = 0; lane < 9; lane++) begin
				for (int b = 0; b < 4; b++) begin
					t[lane*8+b] = half ? d[lane*8+b+4] : d[lane*8+b]; // RL1 RL3
					t[lane*8+b+4] = 1'b1; // RL2
				end
			end
		end
		if (!pin_on) begin
			t[71:64] = 8'hFF; // RL4
		end
		return t;
	endfunction : build_tree

	// count of zero bits in one lane
	function automatic logic [3:0] zeros(input logic [7:0] v);
		logic [3:0] z;
		z = 4'h0;
		for (int i = 0; i < 8; i++) begin
			z = z + {3'h0, ~v[i]};
		end
		return z;
	endfunction : zeros

	assign write_ready = s.write_ready;
	assign error_status = s.error_status;
	assign readout_error_flag = s.readout_flag;
	assign mask_enabled = s.mask_en;
	assign write_invert_enabled = s.winv_en;
	assign read_invert_enabled = s.rinv_en;
	assign termination_strobe_enabled = s.tso_en;
	assign error_flag_line_out = 1'b0;
	assign error_flag_line_oe = s.alert_drive; // RL6 RL10
	assign read_valid = s.read_valid;
	assign read_dq = s.read_dq;
	assign read_invert_flag = s.read_flag;
	assign trigger = s.stage_valid & s.stage_fresh & s.stage_mismatch;

	// accepted words wait here when storage stalls
	pair_buffer #(
		.WIDTH(72),
		.DEPTH(BUFFER_DEPTH)
	) u_buffer (
		.clk_sys(clk_sys),
		.reset(reset),
		.in_valid(s.stage_valid & ~s.stage_drop),
		.in_ready(buf_in_ready),
		.in_data({s.stage_enable, s.stage_data}),
		.out_valid(storage_valid),
		.out_ready(storage_ready),
		.out_data({storage_enable, storage_data})
	);

	// next state of the whole block
	always_comb begin
		logic accept;
		logic leave;
		logic pin_on;
		logic start;
		logic [7:0] lane_byte;
		logic [7:0] calc;
		accept = 1'b0;
		leave = 1'b0;
		pin_on = 1'b0;
		start = 1'b0;
		lane_byte = 8'h00;
		calc = 8'h00;
		next_s = s;
		accept = burst_valid & s.write_ready;
		leave = s.stage_valid & (s.stage_drop | buf_in_ready);
		pin_on = (s.mask_en | s.winv_en) & ~s.tso_en; // RL21
		calc = crc8(build_tree(burst_data, chopped_four_beat_burst, burst_half_select, pin_on));
		next_s.stage_fresh = 1'b0;
		if (leave) begin
			next_s.stage_valid = 1'b0;
		end
		// capture a burst: compare, invert, mask
		if (accept) begin
			next_s.stage_valid = 1'b1;
			next_s.stage_fresh = 1'b1;
			next_s.stage_mismatch = calc != burst_checksum; // RL5 RL26
			next_s.stage_drop = s.mask_en & (calc != burst_checksum);
			for (int b = 0; b < 8; b++) begin
				for (int lane = 0; lane < 8; lane++) begin
					lane_byte[lane] = burst_data[lane*8+b];
				end
				if (s.winv_en && !burst_data[64+b]) begin
					lane_byte = ~lane_byte; // RL20
				end
				next_s.stage_data[b*8 +: 8] = lane_byte;
				next_s.stage_enable[b] = (!s.mask_en || burst_data[64+b]) &&
					(!chopped_four_beat_burst || b < 4);
			end
		end
		next_s.write_ready = ~next_s.stage_valid;
		// mode words; a written one never sets the status bit
		if (mode_set_command) begin
			if (mode_set_select) begin
				next_s.mask_en = mode_set_value[`MW5_MASK_BIT];
				next_s.winv_en = mode_set_value[`MW5_WINV_BIT] & INVERT_ALLOWED; // RL18
				next_s.rinv_en = mode_set_value[`MW5_RINV_BIT] & INVERT_ALLOWED; // RL18
				if (!mode_set_value[`MW5_STATUS_BIT]) begin
					next_s.error_status = 1'b0; // RL13
					next_s.readout_flag = 1'b0; // RL13
				end
			end else begin
				next_s.tso_en = mode_set_value[`MW1_TSO_BIT];
			end
		end
		// sticky status, set wins over clear
		if (trigger) begin
			next_s.error_status = 1'b1; // RL11
			next_s.readout_flag = 1'b1; // RL12
		end
		// error pulse: fixed latency, then a short low drive
		case (s.alert_state)
			write_crc_pkg::ALERT_IDLE: begin
				start = trigger | s.alert_pending;
			end
			write_crc_pkg::ALERT_WAIT: begin
				if (s.alert_count == 8'h00) begin
					next_s.alert_state = write_crc_pkg::ALERT_DRIVE;
					next_s.alert_count = PULSE_COUNT; // RL7 RL17
				end else begin
					next_s.alert_count = s.alert_count - 8'h01;
				end
			end
			write_crc_pkg::ALERT_DRIVE: begin
				if (s.alert_count == 8'h00) begin
					next_s.alert_state = write_crc_pkg::ALERT_IDLE;
					start = s.alert_pending;
				end else begin
					next_s.alert_count = s.alert_count - 8'h01;
				end
			end
			default: begin
				next_s.alert_state = write_crc_pkg::ALERT_IDLE;
			end
		endcase
		if (start) begin
			next_s.alert_state = write_crc_pkg::ALERT_WAIT; // RL5 RL26
			next_s.alert_count = LAT_COUNT;
			next_s.alert_pending = 1'b0;
		end
		if (trigger && s.alert_state != write_crc_pkg::ALERT_IDLE) begin
			next_s.alert_pending = 1'b1;
		end
		next_s.alert_drive = next_s.alert_state == write_crc_pkg::ALERT_DRIVE; // RL10
		// read lane inversion, never on readout reads
		next_s.read_valid = read_beat_valid;
		if (read_beat_valid) begin
			if (s.rinv_en && !read_from_readout && zeros(read_beat) > `READ_ZERO_LIMIT) begin
				next_s.read_dq = ~read_beat; // RL19
				next_s.read_flag = 1'b0;
			end else begin
				next_s.read_dq = read_beat; // RL23
				next_s.read_flag = 1'b1;
			end
		end
	end

	// state register
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			s <= '0;
			s.write_ready <= 1'b1;
			s.read_flag <= 1'b1;
			s.mask_en <= `MODE_FIELD_RESET;
			s.winv_en <= `MODE_FIELD_RESET;
			s.rinv_en <= `MODE_FIELD_RESET;
			s.tso_en <= `MODE_FIELD_RESET;
		end else begin
			s <= next_s;
		end
	end

	localparam int ALERT_QUIET = LAT_CYC;

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (reset);

	chk_alert_latency: assert property ((trigger && s.alert_state == write_crc_pkg::ALERT_IDLE)
		|-> ##ALERT_QUIET !error_flag_line_oe ##1 error_flag_line_oe) // RL26
		else $error("error pulse did not start at the fixed latency");
	chk_pulse_width: assert property ($rose(error_flag_line_oe)
		|-> error_flag_line_oe[*6] ##1 !error_flag_line_oe) // RL7
		else $error("error pulse width is not six clocks");
	chk_pulse_short: assert property ($rose(error_flag_line_oe)
		|-> ##[1:10] !error_flag_line_oe) // RL10
		else $error("error pulse longer than ten clocks");
	chk_status_set: assert property (trigger |=> error_status && readout_error_flag) // RL11
		else $error("mismatch did not set status and flag");
	chk_status_hold: assert property ((error_status && !(mode_set_command && mode_set_select
		&& !mode_set_value[3])) |=> error_status) // RL13
		else $error("status bit dropped without a clear");
	chk_flag_mirror: assert property (error_status == readout_error_flag) // RL12
		else $error("readout flag differs from status bit");
	chk_write_invert: assert property ((burst_valid && write_ready && write_invert_enabled
		&& !burst_data[64]) |=> s.stage_data[0] == !$past(burst_data[0])) // RL20
		else $error("flagged lane was not inverted");
	chk_readout_plain: assert property ((read_beat_valid && read_from_readout)
		|=> read_invert_flag && read_dq == $past(read_beat)) // RL23
		else $error("readout read was inverted");
	chk_mismatch_next: assert property ((burst_valid && write_ready
		&& s.alert_state == write_crc_pkg::ALERT_IDLE) ##1 s.stage_mismatch
		|=> s.alert_state == write_crc_pkg::ALERT_WAIT) // RL5
		else $error("error reporting did not begin on the next clock");

	cov_error_pulse: cover property ($fell(error_flag_line_oe));
	cov_dropped_write: cover property (s.stage_valid && s.stage_drop);
	cov_read_invert: cover property (read_valid && !read_invert_flag);
	cov_pending_error: cover property (s.alert_pending);

endmodule : write_crc_check

// ### rtl/write_crc_map.svh
// Purpose: offsets, field positions and timing counts of the write checksum block
// Assumes: 20 MHz command clock
// Notes: definitions only
`ifndef WRITE_CRC_MAP_SVH
`define WRITE_CRC_MAP_SVH

// mode word five field positions
`define MW5_STATUS_BIT 3
`define MW5_MASK_BIT 10
`define MW5_WINV_BIT 11
`define MW5_RINV_BIT 12
// mode word one field position
`define MW1_TSO_BIT 11
// readout page one, register three, error flag position
`define RP3_FLAG_BIT 7
// reset values of the mode fields
`define MODE_FIELD_RESET 1'b0
// timing
`define CLK_PERIOD_NS 50
`define ERR_LATENCY_NS 150
`define ERR_PULSE_CLOCKS 8'h06
`define ERR_PULSE_MAX_CLOCKS 10
// checksum tree
`define TREE_BITS 72
`define CHOPPED_INPUT_BITS 36
`define CRC_POLY 8'h07
`define CRC_INIT 8'h00
// read inversion threshold of zero bits per lane
`define READ_ZERO_LIMIT 4'h4

`endif

// ### rtl/write_crc_pkg.sv
// Purpose: types of the write checksum block
// Assumes: nothing
// Notes: numbers live in write_crc_map.svh
package write_crc_pkg;

	typedef enum logic [1:0] {
		ALERT_IDLE = 2'b00,
		ALERT_WAIT = 2'b01,
		ALERT_DRIVE = 2'b10
	} alert_state_e;

endpackage : write_crc_pkg

// ### rtl/pair_buffer.sv
// Purpose: small shift-register buffer between write stage and storage
// Assumes: one clock, synchronous reset
// Notes: head entry and both flags come straight from flip-flops
`timescale 1ns/1ns
module pair_buffer #(
	parameter int WIDTH = 72,
	parameter int DEPTH = 2
) (
	input wire logic clk_sys,
	input wire logic reset,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	generate
		if (DEPTH < 2 || DEPTH > 15 || WIDTH < 1) begin : g_bad
			$error("pair_buffer: DEPTH must be 2..15 and WIDTH positive");
		end
	endgenerate

	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] entry;
		logic [3:0] count;
		logic in_ready;
		logic out_valid;
	} buf_state_s;

	buf_state_s s;
	buf_state_s next_s;

	assign in_ready = s.in_ready;
	assign out_valid = s.out_valid;
	assign out_data = s.entry[0];

	// pop shifts toward the head, push lands behind the last entry
	always_comb begin
		logic push;
		logic pop;
		logic [3:0] slot;
		push = 1'b0;
		pop = 1'b0;
		slot = 4'h0;
		next_s = s;
		push = in_valid & s.in_ready;
		pop = s.out_valid & out_ready;
		if (pop) begin
			for (int i = 0; i < DEPTH - 1; i++) begin
				next_s.entry[i] = s.entry[i+1];
			end
		end
		slot = s.count - {3'h0, pop};
		if (push) begin
			next_s.entry[slot[$clog2(DEPTH)-1:0]] = in_data;
		end
		next_s.count = s.count + {3'h0, push} - {3'h0, pop};
		next_s.in_ready = next_s.count < 4'(DEPTH);
		next_s.out_valid = next_s.count != 4'h0;
	end

	// state register
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			s <= '0;
			s.in_ready <= 1'b1;
		end else begin
			s <= next_s;
		end
	end

endmodule : pair_buffer

// ### verif/controller_model.sv
// Purpose: controller end of the shared open-drain error line
// Assumes: pull-up at this end, one clock
// Notes: measures each low period in clocks and counts them
`timescale 1ns/1ns
module controller_model (
	input wire logic clk_sys,
	input wire logic reset,
	input wire logic error_flag_line_out,
	input wire logic error_flag_line_oe,
	output logic error_line,
	output logic [7:0] low_width,
	output logic [7:0] pulse_count
);
	logic [7:0] run;
	// released line is pulled back high here
	assign error_line = error_flag_line_oe ? error_flag_line_out : 1'b1;
	// low period length tells checksum pulses from long ones
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			run <= 8'h00;
			low_width <= 8'h00;
			pulse_count <= 8'h00;
		end else if (!error_line) begin
			run <= run + 8'h01;
		end else if (run != 8'h00) begin
			low_width <= run;
			pulse_count <= pulse_count + 8'h01;
			run <= 8'h00;
		end
	end
endmodule : controller_model

// ### verif/tb.sv
// Purpose: self-checking bench of the write checksum block
// Assumes: 20 MHz clock, eight-bit device
// Notes: seed 64, random bursts mixed with fixed corner cases
`timescale 1ns/1ns
`include "write_crc_map.svh"
module tb;
	logic clk_sys = 1'b0;
	logic reset = 1'b1;
	logic burst_valid = 1'b0;
	logic [71:0] burst_data = 72'h0;
	logic chop = 1'b0;
	logic half = 1'b0;
	logic [7:0] burst_checksum = 8'h00;
	logic mode_set_command = 1'b0;
	logic mode_set_select = 1'b0;
	logic [15:0] mode_set_value = 16'h0000;
	logic storage_ready = 1'b1;
	logic [31:0] ready_pat = 32'hFFFFFFFF;
	logic [4:0] stall_rot = 5'h00;
	logic read_beat_valid = 1'b0;
	logic [7:0] read_beat = 8'h00;
	logic read_from_readout = 1'b0;
	logic write_ready, storage_valid, read_valid, read_invert_flag, line_out, line_oe;
	logic error_status, readout_error_flag, mask_on, winv_on, rinv_on, tso_on, error_line;
	logic [63:0] storage_data;
	logic [7:0] storage_enable, read_dq, low_width, pulse_count;
	logic m_mask, m_winv, m_rinv, m_tso;
	logic [71:0] exp_q[$];
	logic [71:0] e;
	logic [63:0] bm;
	int fails = 0;
	int samples_checked = 0;
	int cycles = 0;
	int nbad = 0;
	always #25 clk_sys = ~clk_sys;
	write_crc_check dut (.clk_sys(clk_sys), .reset(reset), .burst_valid(burst_valid),
		.write_ready(write_ready), .burst_data(burst_data), .chopped_four_beat_burst(chop),
		.burst_half_select(half), .burst_checksum(burst_checksum),
		.mode_set_command(mode_set_command), .mode_set_select(mode_set_select),
		.mode_set_value(mode_set_value), .storage_valid(storage_valid),
		.storage_ready(storage_ready), .storage_data(storage_data),
		.storage_enable(storage_enable), .read_beat_valid(read_beat_valid),
		.read_beat(read_beat), .read_from_readout(read_from_readout), .read_valid(read_valid),
		.read_dq(read_dq), .read_invert_flag(read_invert_flag), .error_flag_line_in(error_line),
		.error_flag_line_out(line_out), .error_flag_line_oe(line_oe),
		.error_status(error_status), .readout_error_flag(readout_error_flag),
		.mask_enabled(mask_on), .write_invert_enabled(winv_on), .read_invert_enabled(rinv_on),
		.termination_strobe_enabled(tso_on));
	controller_model ctl (.clk_sys(clk_sys), .reset(reset), .error_flag_line_out(line_out),
		.error_flag_line_oe(line_oe), .error_line(error_line), .low_width(low_width),
		.pulse_count(pulse_count));
	task automatic cmp_vec(input string n, input logic [71:0] x, input logic [71:0] g);
		samples_checked++;
		if (g !== x) begin
			fails++;
			$display("[FAIL] %s expected %h seen %h", n, x, g);
		end
	endtask : cmp_vec
	task automatic cmp_flag(input string n, input logic x, input logic g);
		cmp_vec(n, {71'h0, x}, {71'h0, g});
	endtask : cmp_flag
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : report_and_stop
	// serial checksum over the tree bits, chopped beats filled with ones
	function automatic logic [7:0] exp_crc(logic [71:0] d, logic ch, logic hf, logic pin);
		logic [71:0] t;
		logic [7:0] c;
		t = d;
		c = 8'h00;
		for (int l = 0; l < 9; l++) begin
			for (int b = 0; b < 4; b++) begin
				if (ch) begin
					t[l*8+b] = hf ? d[l*8+b+4] : d[l*8+b];
					t[l*8+b+4] = 1'b1;
				end
			end
		end
		if (!pin) begin
			t[71:64] = 8'hFF;
		end
		for (int i = 0; i < 72; i++) begin
			c = {c[6:0], 1'b0} ^ ((c[7] ^ t[i]) ? 8'h07 : 8'h00);
		end
		return c;
	endfunction : exp_crc
	// stored word: byte per beat, inverted where the lane flag is low
	function automatic logic [71:0] exp_store(logic [71:0] d, logic ch, logic inv);
		logic [71:0] r;
		r = 72'h0;
		for (int b = 0; b < 8; b++) begin
			for (int k = 0; k < 8; k++) begin
				r[b*8+k] = (d[k*8+b] ^ (inv & ~d[64+b])) & ~(ch & (b > 3));
			end
			r[64+b] = ~(ch & (b > 3));
		end
		return r;
	endfunction : exp_store
	task automatic set_mode(input logic mk, input logic wi, input logic ri, input logic ts,
		input logic keep);
		logic [15:0] v;
		v = 16'h0000;
		v[`MW5_MASK_BIT] = mk;
		v[`MW5_WINV_BIT] = wi;
		v[`MW5_RINV_BIT] = ri;
		v[`MW5_STATUS_BIT] = keep;
		@(posedge clk_sys);
		mode_set_command <= 1'b1;
		mode_set_select <= 1'b1;
		mode_set_value <= v;
		@(posedge clk_sys);
		mode_set_select <= 1'b0;
		mode_set_value <= 16'h0000 | (16'h0001 << `MW1_TSO_BIT) & {16{ts}};
		@(posedge clk_sys);
		mode_set_command <= 1'b0;
		{m_mask, m_winv, m_rinv, m_tso} = {mk, wi, ri, ts};
		#1 cmp_vec("modes", {68'h0, mk, wi, ri, ts}, {68'h0, mask_on, winv_on, rinv_on, tso_on});
	endtask : set_mode
	task automatic send(input logic [71:0] d, input logic ch, input logic hf, input logic bad);
		logic [7:0] c;
		c = exp_crc(d, ch, hf, (m_mask | m_winv) & ~m_tso) ^ {7'h00, bad};
		if (!(bad && m_mask)) exp_q.push_back(exp_store(d, ch, m_winv));
		@(posedge clk_sys);
		{burst_valid, burst_data, chop, half, burst_checksum} <= {1'b1, d, ch, hf, c};
		do @(posedge clk_sys); while (write_ready !== 1'b1);
		burst_valid <= 1'b0;
		if (bad) begin
			nbad++;
			repeat (3) @(posedge clk_sys);
			#1 cmp_flag("oe_wait", 1'b0, line_oe);
			cmp_vec("status", 2'b11, {error_status, readout_error_flag});
			@(posedge clk_sys);
			#1 cmp_flag("oe_start", 1'b1, line_oe);
			repeat (6) @(posedge clk_sys);
			#1 cmp_flag("oe_end", 1'b0, line_oe);
			@(posedge clk_sys);
			#1 cmp_vec("width", `ERR_PULSE_CLOCKS, low_width);
			send(d, ch, hf, 1'b0);
		end
	endtask : send
	task automatic read(input logic [7:0] b, input logic ro);
		logic inv;
		inv = m_rinv & ~ro & ($countones(~b) > 4);
		@(posedge clk_sys);
		{read_beat_valid, read_beat, read_from_readout} <= {1'b1, b, ro};
		@(posedge clk_sys);
		read_beat_valid <= 1'b0;
		#1 cmp_vec("read", {1'b1, inv ? ~b : b, ~inv}, {read_valid, read_dq, read_invert_flag});
	endtask : read
	// stored words leave in order; unwritten beats are not compared
	always @(posedge clk_sys) begin
		if (!reset && storage_valid === 1'b1 && storage_ready) begin
			e = exp_q.pop_front();
			for (int b = 0; b < 8; b++) bm[b*8+:8] = {8{e[64+b]}};
			cmp_vec("store", e, {storage_enable, storage_data & bm});
		end
	end
	// storage side ready follows a rotating pattern, so a stall never lasts forever
	always @(posedge clk_sys) begin
		stall_rot <= stall_rot + 5'h01;
		storage_ready <= ready_pat[stall_rot];
	end
	always @(posedge clk_sys) begin
		cycles <= cycles + 1;
		if (cycles == 30000) begin
			fails++;
			report_and_stop();
		end
	end
	initial begin
		logic [71:0] d;
		logic [1:0] m;
		void'($urandom(64));
		{m_mask, m_winv, m_rinv, m_tso} = 4'h0;
		repeat (16) @(posedge clk_sys);
		reset <= 1'b0;
		#1 cmp_vec("reset", 8'h88, {write_ready, line_oe, error_status, storage_valid,
			read_invert_flag, mask_on, winv_on, tso_on});
		$display("test reset done");
		// error sets sticky status, clear only by mode set with bit three low
		send(72'h123456789ABCDEF012, 1'b0, 1'b0, 1'b1);
		send(72'hFF0F1E2D3C4B5A6978, 1'b1, 1'b1, 1'b0);
		set_mode(1'b0, 1'b0, 1'b0, 1'b0, 1'b1);
		cmp_vec("kept", 2'b11, {error_status, readout_error_flag});
		set_mode(1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
		cmp_vec("cleared", 2'b00, {error_status, readout_error_flag});
		$display("test status done");
		// buffer full with the storage side stalled, then drained
		ready_pat <= 32'h00000000;
		for (int i = 0; i < 3; i++) send({$urandom, $urandom, $urandom}, i[0], 1'b0, 1'b0);
		repeat (4) @(posedge clk_sys);
		#1 cmp_vec("full", 2'b01, {write_ready, storage_valid});
		ready_pat <= 32'hFFFFFFFF;
		repeat (8) @(posedge clk_sys);
		cmp_vec("drained", 0, exp_q.size());
		$display("test buffer done");
		// random bursts across every legal pin function, storage stalling at random
		for (int i = 0; i < 48; i++) begin
			m = $urandom_range(0, 3);
			if (i % 6 == 0) set_mode(m == 1, m == 2, m != 3 && $urandom_range(0, 1) == 1,
				m == 3, 1'b1);
			d = {$urandom, $urandom, $urandom};
			if (m_mask) d[71:64] = 8'hFF;
			ready_pat <= $urandom | $urandom | 32'h00000001;
			send(d, $urandom, $urandom, $urandom_range(0, 5) == 0);
		end
		ready_pat <= 32'hFFFFFFFF;
		repeat (12) @(posedge clk_sys);
		cmp_vec("pulses", nbad, pulse_count);
		cmp_vec("left", 0, exp_q.size());
		$display("test random done");
		// read inversion by zero count, never on readout reads
		set_mode(1'b0, 1'b0, 1'b1, 1'b0, 1'b0);
		read(8'h00, 1'b0);
		read(8'h0F, 1'b0);
		read(8'h07, 1'b0);
		read(8'h00, 1'b1);
		for (int i = 0; i < 16; i++) read($urandom, $urandom);
		set_mode(1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
		read(8'h00, 1'b0);
		$display("test read done");
		report_and_stop();
	end
endmodule : tb
